// ==== include/osft_pkg.sv ====
// constants and types for the single pulse timer and blink generator
package osft_pkg;

	// ----------------------------------------
	// clock and timebase
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int TB_10MS_NS = 10_000_000;
	localparam int TICK10_CYCLES = TB_10MS_NS / CLK_PERIOD_NS;
	localparam int DECADE = 10;
	localparam int TICK_CNT_W = 18;
	localparam int DEC_CNT_W = 4;

	// ----------------------------------------
	// register port
	// ----------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	typedef logic [ADDR_W-1:0] osft_addr_type;
	typedef logic [DATA_W-1:0] osft_data_type;

	// word indices
	localparam osft_addr_type OS_CTRL_IDX = 4'h0;
	localparam osft_addr_type OS_MAIN_IDX = 4'h1;
	localparam osft_addr_type OS_SECOND_IDX = 4'h2;
	localparam osft_addr_type OS_CUR_IDX = 4'h3;
	localparam osft_addr_type FL_CTRL_IDX = 4'h4;
	localparam osft_addr_type FL_ON_IDX = 4'h5;
	localparam osft_addr_type FL_OFF_IDX = 4'h6;
	localparam osft_addr_type FL_COUNT_IDX = 4'h7;
	localparam osft_addr_type FL_CUR_ON_IDX = 4'h8;
	localparam osft_addr_type FL_CUR_OFF_IDX = 4'h9;
	localparam osft_addr_type FL_CUR_CNT_IDX = 4'hA;
	localparam osft_addr_type STATUS_IDX = 4'hB;

	// ----------------------------------------
	// fields and values
	// ----------------------------------------
	localparam int UNIT_LSB = 0;
	localparam int UNIT_W = 2;
	localparam int OS_PRIO_BIT = 2;
	localparam int FL_MODE_LSB = 2;
	localparam int MODE_W = 2;
	localparam int STAT_OS_BIT = 0;
	localparam int STAT_FL_BIT = 1;
	localparam int STAT_FL_RUN_BIT = 2;
	localparam int VAL_W = 15;
	typedef logic [VAL_W-1:0] osft_val_type;
	localparam osft_val_type VAL_MAX = 15'h7FFF;
	localparam osft_val_type VAL_RESET = 15'h0000;
	localparam osft_val_type VAL_ONE = 15'h0001;

	typedef enum logic [UNIT_W-1:0] {UNIT_10MS, UNIT_100MS, UNIT_1S} osft_unit_type;
	typedef enum logic [MODE_W-1:0] {MODE_CONT, MODE_CYCLES, MODE_TIME} osft_mode_type;

endpackage

// ==== include/osft_tick_if.sv ====
// timebase tick enables shared between the divider and the timers
`timescale 1ns/1ps
`default_nettype none
interface osft_tick_if;
	logic tick_10ms;
	logic tick_100ms;
	logic tick_1s;
	modport src (output tick_10ms, output tick_100ms, output tick_1s);
	modport snk (input tick_10ms, input tick_100ms, input tick_1s);
endinterface
`default_nettype wire

// ==== rtl/osft_tick_gen.sv ====
// timebase divider: 10 ms, 100 ms and 1 s one-cycle enables
`timescale 1ns/1ps
`default_nettype none
module osft_tick_gen #(
	parameter int TICK10_CYCLES = osft_pkg::TICK10_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	osft_tick_if.src tk
);
	import osft_pkg::*;

	typedef struct packed {
		logic [TICK_CNT_W-1:0] cnt10;
		logic [DEC_CNT_W-1:0] cnt100;
		logic [DEC_CNT_W-1:0] cnt1s;
		logic t10;
		logic t100;
		logic t1s;
	} osft_tick_state_type;

	localparam logic [TICK_CNT_W-1:0] TOP10 = TICK_CNT_W'(TICK10_CYCLES - 1);
	localparam logic [DEC_CNT_W-1:0] TOPDEC = DEC_CNT_W'(DECADE - 1);

	osft_tick_state_type state_reg;
	osft_tick_state_type state_next;

	// ----------------------------------------
	// divider chain
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.t10 = 1'b0;
		state_next.t100 = 1'b0;
		state_next.t1s = 1'b0;
		if (state_reg.cnt10 == TOP10) begin
			state_next.cnt10 = '0;
			state_next.t10 = 1'b1;
			if (state_reg.cnt100 == TOPDEC) begin
				state_next.cnt100 = '0;
				state_next.t100 = 1'b1;
				if (state_reg.cnt1s == TOPDEC) begin
					state_next.cnt1s = '0;
					state_next.t1s = 1'b1;
				end else begin
					state_next.cnt1s = state_reg.cnt1s + 1'b1;
				end
			end else begin
				state_next.cnt100 = state_reg.cnt100 + 1'b1;
			end
		end else begin
			state_next.cnt10 = state_reg.cnt10 + 1'b1;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign tk.tick_10ms = state_reg.t10;
	assign tk.tick_100ms = state_reg.t100;
	assign tk.tick_1s = state_reg.t1s;

endmodule
`default_nettype wire

// ==== rtl/osft_timer.sv ====
// single pulse timer and blink generator with register port
//
// Operation
// [RL1] pulse length counts ticks of 10 ms, 100 ms or 1 s
// [RL2] pulse length setting spans 0 to 32767 timebase units
// [RL3] trigger drives output on for the set length, then off
// [RL4] clear forces output off at once, over the trigger
// [RL5] zero length gives a one-scan pulse per trigger edge
// [RL6] a setting picks time priority or input priority
// [RL7] time priority runs full length; input priority ends when input drops
// [RL8] main length and a second time value are both stored
// [RL9] set length and elapsed time are readable
// [RL10] software sets times no shorter than one scan
// [RL11] on interval spans 0 to 32767 units of selectable timebase
// [RL12] off interval is independent, same timebase
// [RL13] run modes: cycle count, run time count, continuous
// [RL14] continuous mode blinks only while trigger is high, else off
// [RL15] set and current on, off and count values are readable
// [RL16] each cycle is on then off; output ends off when done
`timescale 1ns/1ps
`default_nettype none
module osft_timer #(
	parameter int TICK10_CYCLES = osft_pkg::TICK10_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire osft_pkg::osft_addr_type reg_addr,
	input wire osft_pkg::osft_data_type reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output osft_pkg::osft_data_type reg_rdata,
	input wire logic os_trig_pin,
	input wire logic os_clear_pin,
	input wire logic fl_trig_pin,
	output logic os_out,
	output logic fl_out
);
	import osft_pkg::*;

	typedef enum logic [1:0] {FL_IDLE, FL_ON, FL_OFF} osft_fl_state_type;

	typedef struct packed {
		// pin synchronisers
		logic os_trig_s1;
		logic os_trig_s2;
		logic os_trig_d;
		logic os_clr_s1;
		logic os_clr_s2;
		logic fl_trig_s1;
		logic fl_trig_s2;
		logic fl_trig_d;
		// single pulse timer
		osft_unit_type os_unit;
		logic os_input_prio;
		osft_val_type os_main;
		osft_val_type os_second;
		osft_val_type os_cur;
		logic os_on;
		// blink generator
		osft_unit_type fl_unit;
		osft_mode_type fl_mode;
		osft_val_type fl_on_set;
		osft_val_type fl_off_set;
		osft_val_type fl_cnt_set;
		osft_val_type fl_cur_on;
		osft_val_type fl_cur_off;
		osft_val_type fl_cur_cnt;
		osft_fl_state_type fl_state;
		// read data
		osft_data_type rdata;
	} osft_state_type;

	osft_state_type state_reg;
	osft_state_type state_next;

	osft_tick_if tick_bus ();

	// ----------------------------------------
	// timebase
	// ----------------------------------------
	osft_tick_gen #(
		.TICK10_CYCLES(TICK10_CYCLES)
	) u_tick (
		.clock(clock),
		.rst(rst),
		.tk(tick_bus)
	);

	function automatic logic pick_tick(osft_unit_type u, logic t10, logic t100, logic t1s);
		logic t;
		t = t1s;
		if (u == UNIT_10MS) begin
			t = t10;
		end else if (u == UNIT_100MS) begin
			t = t100;
		end
		return t;
	endfunction

	function automatic osft_val_type sat_inc(osft_val_type v);
		osft_val_type r;
		r = v;
		if (v != VAL_MAX) begin
			r = v + VAL_ONE;
		end
		return r;
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic os_tick;
		logic fl_tick;
		logic os_rise;
		logic fl_rise;
		logic fl_running;
		osft_val_type wval;
		os_tick = pick_tick(state_reg.os_unit, tick_bus.tick_10ms,
			tick_bus.tick_100ms, tick_bus.tick_1s); // [RL1]
		fl_tick = pick_tick(state_reg.fl_unit, tick_bus.tick_10ms,
			tick_bus.tick_100ms, tick_bus.tick_1s); // [RL11] [RL12]
		os_rise = state_reg.os_trig_s2 & ~state_reg.os_trig_d;
		fl_rise = state_reg.fl_trig_s2 & ~state_reg.fl_trig_d;
		fl_running = 1'b0;
		wval = reg_wdata[VAL_W-1:0];

		state_next = state_reg;
		state_next.os_trig_s1 = os_trig_pin;
		state_next.os_trig_s2 = state_reg.os_trig_s1;
		state_next.os_trig_d = state_reg.os_trig_s2;
		state_next.os_clr_s1 = os_clear_pin;
		state_next.os_clr_s2 = state_reg.os_clr_s1;
		state_next.fl_trig_s1 = fl_trig_pin;
		state_next.fl_trig_s2 = state_reg.fl_trig_s1;
		state_next.fl_trig_d = state_reg.fl_trig_s2;
		state_next.rdata = '0;

		// ----------------------------------------
		// register writes
		// ----------------------------------------
		if (reg_wr) begin
			if (reg_addr == OS_CTRL_IDX) begin
				state_next.os_unit = osft_unit_type'(reg_wdata[UNIT_LSB +: UNIT_W]); // [RL1]
				state_next.os_input_prio = reg_wdata[OS_PRIO_BIT]; // [RL6]
			end else if (reg_addr == OS_MAIN_IDX) begin
				state_next.os_main = wval; // [RL2] [RL8]
			end else if (reg_addr == OS_SECOND_IDX) begin
				state_next.os_second = wval; // [RL8]
			end else if (reg_addr == FL_CTRL_IDX) begin
				state_next.fl_unit = osft_unit_type'(reg_wdata[UNIT_LSB +: UNIT_W]);
				state_next.fl_mode = osft_mode_type'(reg_wdata[FL_MODE_LSB +: MODE_W]); // [RL13]
			end else if (reg_addr == FL_ON_IDX) begin
				state_next.fl_on_set = wval; // [RL11]
			end else if (reg_addr == FL_OFF_IDX) begin
				state_next.fl_off_set = wval; // [RL12]
			end else if (reg_addr == FL_COUNT_IDX) begin
				state_next.fl_cnt_set = wval; // [RL13]
			end
		end

		// ----------------------------------------
		// single pulse timer
		// ----------------------------------------
		if (state_reg.os_clr_s2) begin
			state_next.os_on = 1'b0; // [RL4]
			state_next.os_cur = VAL_RESET;
		end else if (!state_reg.os_on) begin
			if (os_rise) begin
				state_next.os_on = 1'b1; // [RL3]
				state_next.os_cur = VAL_RESET;
			end
		end else if (state_reg.os_cur >= state_reg.os_main) begin
			state_next.os_on = 1'b0; // [RL3] [RL5]
		end else if (state_reg.os_input_prio && !state_reg.os_trig_s2) begin
			state_next.os_on = 1'b0; // [RL7]
		end else if (os_tick) begin
			state_next.os_cur = sat_inc(state_reg.os_cur); // [RL3]
		end

		// ----------------------------------------
		// blink generator
		// ----------------------------------------
		case (state_reg.fl_state)
			FL_IDLE: begin
				if (state_reg.fl_mode == MODE_CYCLES || state_reg.fl_mode == MODE_TIME) begin
					if (fl_rise) begin
						state_next.fl_state = FL_ON; // [RL16]
						state_next.fl_cur_on = VAL_RESET;
						state_next.fl_cur_off = VAL_RESET;
						state_next.fl_cur_cnt = VAL_RESET;
					end
				end else if (state_reg.fl_trig_s2) begin
					state_next.fl_state = FL_ON; // [RL14]
					state_next.fl_cur_on = VAL_RESET;
					state_next.fl_cur_off = VAL_RESET;
					state_next.fl_cur_cnt = VAL_RESET;
				end
			end
			FL_ON: begin
				fl_running = 1'b1;
				if (state_reg.fl_cur_on >= state_reg.fl_on_set) begin
					state_next.fl_state = FL_OFF; // [RL16]
					state_next.fl_cur_off = VAL_RESET;
				end else if (fl_tick) begin
					state_next.fl_cur_on = sat_inc(state_reg.fl_cur_on); // [RL11]
				end
			end
			FL_OFF: begin
				fl_running = 1'b1;
				if (state_reg.fl_cur_off >= state_reg.fl_off_set) begin
					state_next.fl_state = FL_ON; // [RL16]
					state_next.fl_cur_on = VAL_RESET;
					if (state_reg.fl_mode == MODE_CYCLES) begin
						state_next.fl_cur_cnt = sat_inc(state_reg.fl_cur_cnt);
						if (sat_inc(state_reg.fl_cur_cnt) >= state_reg.fl_cnt_set) begin
							state_next.fl_state = FL_IDLE; // [RL13] [RL16]
						end
					end
				end else if (fl_tick) begin
					state_next.fl_cur_off = sat_inc(state_reg.fl_cur_off); // [RL12]
				end
			end
			default: begin
				state_next.fl_state = FL_IDLE;
			end
		endcase

		// run time count and continuous gate override the cycle walk
		if (fl_running && state_reg.fl_mode == MODE_TIME) begin
			if (state_reg.fl_cur_cnt >= state_reg.fl_cnt_set) begin
				state_next.fl_state = FL_IDLE; // [RL13] [RL16]
			end else if (fl_tick) begin
				state_next.fl_cur_cnt = sat_inc(state_reg.fl_cur_cnt); // [RL13]
			end
		end
		if (fl_running && state_reg.fl_mode != MODE_CYCLES && state_reg.fl_mode != MODE_TIME) begin
			if (!state_reg.fl_trig_s2) begin
				state_next.fl_state = FL_IDLE; // [RL14]
			end
		end

		// ----------------------------------------
		// register reads
		// ----------------------------------------
		if (reg_rd) begin
			if (reg_addr == OS_CTRL_IDX) begin
				state_next.rdata[UNIT_LSB +: UNIT_W] = state_reg.os_unit;
				state_next.rdata[OS_PRIO_BIT] = state_reg.os_input_prio;
			end else if (reg_addr == OS_MAIN_IDX) begin
				state_next.rdata[VAL_W-1:0] = state_reg.os_main; // [RL9]
			end else if (reg_addr == OS_SECOND_IDX) begin
				state_next.rdata[VAL_W-1:0] = state_reg.os_second; // [RL8]
			end else if (reg_addr == OS_CUR_IDX) begin
				state_next.rdata[VAL_W-1:0] = state_reg.os_cur; // [RL9]
			end else if (reg_addr == FL_CTRL_IDX) begin
				state_next.rdata[UNIT_LSB +: UNIT_W] = state_reg.fl_unit;
				state_next.rdata[FL_MODE_LSB +: MODE_W] = state_reg.fl_mode;
			end else if (reg_addr == FL_ON_IDX) begin
				state_next.rdata[VAL_W-1:0] = state_reg.fl_on_set; // [RL15]
			end else if (reg_addr == FL_OFF_IDX) begin
				state_next.rdata[VAL_W-1:0] = state_reg.fl_off_set; // [RL15]
			end else if (reg_addr == FL_COUNT_IDX) begin
				state_next.rdata[VAL_W-1:0] = state_reg.fl_cnt_set; // [RL15]
			end else if (reg_addr == FL_CUR_ON_IDX) begin
				state_next.rdata[VAL_W-1:0] = state_reg.fl_cur_on; // [RL15]
			end else if (reg_addr == FL_CUR_OFF_IDX) begin
				state_next.rdata[VAL_W-1:0] = state_reg.fl_cur_off; // [RL15]
			end else if (reg_addr == FL_CUR_CNT_IDX) begin
				state_next.rdata[VAL_W-1:0] = state_reg.fl_cur_cnt; // [RL15]
			end else if (reg_addr == STATUS_IDX) begin
				state_next.rdata[STAT_OS_BIT] = state_reg.os_on;
				state_next.rdata[STAT_FL_BIT] = (state_reg.fl_state == FL_ON);
				state_next.rdata[STAT_FL_RUN_BIT] = (state_reg.fl_state != FL_IDLE);
			end
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign reg_rdata = state_reg.rdata;
	assign os_out = state_reg.os_on;
	assign fl_out = (state_reg.fl_state == FL_ON);

endmodule
`default_nettype wire

// ==== test/osft_timer_monitor.sv ====
// port checker for the single pulse timer and blink generator
`timescale 1ns/1ps
`default_nettype none
module osft_timer_mon #(
	parameter int TICK10_CYCLES = 4
) (
	input wire logic clock,
	input wire logic rst,
	input wire osft_pkg::osft_addr_type reg_addr,
	input wire osft_pkg::osft_data_type reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire osft_pkg::osft_data_type reg_rdata,
	input wire logic os_trig_pin,
	input wire logic os_clear_pin,
	input wire logic fl_trig_pin,
	input wire logic os_out,
	input wire logic fl_out
);
	import osft_pkg::*;
	// ----------------------------------------
	// sequences and properties
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_trig_rise;
		$rose(os_trig_pin) && !os_clear_pin ##1 os_trig_pin && !os_clear_pin
		##1 os_trig_pin && !os_clear_pin && !os_out;
	endsequence
	sequence s_clr_hold;
		os_clear_pin [*5] ##0 (reg_rd && reg_addr == OS_CUR_IDX);
	endsequence
	AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data not zero outside read answer");
	AST_BIT15: assert property ($past(reg_rd) |-> !reg_rdata[15])
		else $error("read data bit 15 set");
	AST_STAT_OS: assert property (reg_rd && reg_addr == STATUS_IDX
		|=> reg_rdata[STAT_OS_BIT] == $past(os_out)) else $error("status pulse bit wrong");
	AST_STAT_FL: assert property (reg_rd && reg_addr == STATUS_IDX
		|=> reg_rdata[STAT_FL_BIT] == $past(fl_out)) else $error("status blink bit wrong");
	AST_UNMAPPED: assert property (reg_rd && reg_addr > STATUS_IDX
		|=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
	AST_CLR_OFF: assert property (os_clear_pin |-> ##3 !os_out)
		else $error("clear did not force output off");
	AST_OS_START: assert property (s_trig_rise |=> os_out)
		else $error("trigger did not start pulse");
	AST_CLR_CUR: assert property (s_clr_hold |=> reg_rdata == 16'h0000)
		else $error("elapsed value not zero under clear");
endmodule
`default_nettype wire
bind osft_timer osft_timer_mon #(.TICK10_CYCLES(TICK10_CYCLES)) u_osft_timer_mon (
	.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.os_trig_pin(os_trig_pin), .os_clear_pin(os_clear_pin),
	.fl_trig_pin(fl_trig_pin), .os_out(os_out), .fl_out(fl_out)
);

// ==== test/testbench.sv ====
// self-checking bench for the single pulse timer and blink generator
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import osft_pkg::*;
	// ----------------------------------------
	// signals and tasks
	// ----------------------------------------
	localparam int P = 4;
	logic clock = 1'b0;
	logic rst = 1'b1;
	osft_addr_type reg_addr = 4'h0;
	osft_data_type reg_wdata = 16'h0000;
	osft_data_type reg_rdata;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic os_trig_pin = 1'b0;
	logic os_clear_pin = 1'b0;
	logic fl_trig_pin = 1'b0;
	logic os_out;
	logic fl_out;
	int errors = 0;
	int cmp_count = 0;
	always #20 clock = ~clock;
	osft_timer #(.TICK10_CYCLES(P)) u_osft_timer (
		.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.os_trig_pin(os_trig_pin), .os_clear_pin(os_clear_pin),
		.fl_trig_pin(fl_trig_pin), .os_out(os_out), .fl_out(fl_out)
	);
	task automatic summarize();
		if (errors == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic tmo();
		errors++;
		$display("MISMATCH %0t wait timed out", $time);
		summarize();
	endtask
	task automatic chk(osft_data_type got, osft_data_type exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t value %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_rng(int got, int lo, int hi);
		cmp_count++;
		if (got < lo || got > hi) begin
			errors++;
			$display("MISMATCH %0t count %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask
	task automatic wr(osft_addr_type a, osft_data_type d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rc(osft_addr_type a, osft_data_type exp);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask
	task automatic os_len(output int n);
		int i;
		n = 0;
		for (i = 0; i < 20 && os_out !== 1'b1; i++) @(negedge clock);
		if (i == 20) tmo();
		while (os_out === 1'b1 && n < 3000) begin
			@(negedge clock);
			n++;
		end
	endtask
	task automatic os_trig(int hold, output int n);
		@(posedge clock);
		os_trig_pin <= 1'b1;
		fork
			begin
				repeat (hold) @(posedge clock);
				os_trig_pin <= 1'b0;
			end
			os_len(n);
		join
		repeat (4) @(posedge clock);
	endtask
	task automatic fl_cnt(int cyc, output int n);
		logic p;
		n = 0;
		p = fl_out;
		repeat (cyc) begin
			@(negedge clock);
			if (fl_out === 1'b1 && p !== 1'b1) n++;
			p = fl_out;
		end
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		int n;
		int i;
		int per;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		for (i = 0; i < 16; i++) rc(osft_addr_type'(i), 16'h0000);
		wr(OS_MAIN_IDX, 16'hFFFF);
		rc(OS_MAIN_IDX, 16'h7FFF);
		wr(OS_SECOND_IDX, 16'h1234);
		rc(OS_SECOND_IDX, 16'h1234);
		wr(OS_CUR_IDX, 16'h0055);
		rc(OS_CUR_IDX, 16'h0000);
		for (i = 5; i < 8; i++) begin
			wr(osft_addr_type'(i), osft_data_type'(16'h7FF0 + i));
			rc(osft_addr_type'(i), osft_data_type'(16'h7FF0 + i));
		end
		wr(OS_MAIN_IDX, 16'h0000);
		os_trig(5, n);
		chk_rng(n, 1, 1);
		for (i = 0; i < 4; i++) begin
			per = (i == 0) ? P : ((i == 1) ? 10 * P : 100 * P);
			wr(OS_CTRL_IDX, osft_data_type'(i));
			wr(OS_MAIN_IDX, 16'h0002);
			os_trig(5, n);
			chk_rng(n, per, 2 * per + 3);
			rc(OS_CUR_IDX, 16'h0002);
		end
		wr(OS_CTRL_IDX, 16'h0004);
		wr(OS_MAIN_IDX, 16'h0064);
		os_trig(10, n);
		chk_rng(n, 9, 12);
		wr(OS_CTRL_IDX, 16'h0000);
		os_trig_pin <= 1'b1;
		repeat (8) @(posedge clock);
		rc(STATUS_IDX, 16'h0001);
		@(posedge clock);
		os_clear_pin <= 1'b1;
		os_trig_pin <= 1'b0;
		repeat (4) @(posedge clock);
		#1;
		chk({15'h0000, os_out}, 16'h0000);
		@(posedge clock);
		os_trig_pin <= 1'b1;
		repeat (6) @(posedge clock);
		rc(OS_CUR_IDX, 16'h0000);
		chk({15'h0000, os_out}, 16'h0000);
		@(posedge clock);
		os_clear_pin <= 1'b0;
		os_trig_pin <= 1'b0;
		wr(FL_CTRL_IDX, 16'h0004);
		wr(FL_ON_IDX, 16'h0002);
		wr(FL_OFF_IDX, 16'h0001);
		wr(FL_COUNT_IDX, 16'h0003);
		@(posedge clock);
		fl_trig_pin <= 1'b1;
		fork
			begin
				repeat (3) @(posedge clock);
				fl_trig_pin <= 1'b0;
			end
			fl_cnt(120, n);
		join
		chk_rng(n, 3, 3);
		chk({15'h0000, fl_out}, 16'h0000);
		rc(FL_CUR_CNT_IDX, 16'h0003);
		rc(STATUS_IDX, 16'h0000);
		wr(FL_CTRL_IDX, 16'h0008);
		wr(FL_ON_IDX, 16'h0001);
		wr(FL_COUNT_IDX, 16'h000A);
		@(posedge clock);
		fl_trig_pin <= 1'b1;
		fl_cnt(150, n);
		chk_rng(n, 3, 7);
		chk({15'h0000, fl_out}, 16'h0000);
		rc(FL_CUR_CNT_IDX, 16'h000A);
		wr(FL_CTRL_IDX, 16'h0000);
		fl_cnt(80, n);
		chk_rng(n, 6, 12);
		@(posedge clock);
		fl_trig_pin <= 1'b0;
		repeat (5) @(posedge clock);
		fl_cnt(40, n);
		chk_rng(n, 0, 0);
		chk({15'h0000, fl_out}, 16'h0000);
		summarize();
	end
endmodule
`default_nettype wire
